// file: logic/spe_pkg.sv
// types shared by the switch period enable counter
// assumes the constants come from spe_map.svh
package spe_pkg;
  typedef enum logic [0:0] {
    SPE_RELEASED,
    SPE_PULLED
  } spe_state_t;
endpackage

// file: logic/spe_map.svh
// constants for the switch period enable counter
// assumes a 100 MHz sys_clk
`ifndef SPE_MAP_SVH
`define SPE_MAP_SVH
`define SPE_CLK_MHZ        100
`define SPE_DISABLE_NS     177000
`define SPE_ENABLE_NS      140000
`define SPE_DISABLE_CYC    ((`SPE_DISABLE_NS * `SPE_CLK_MHZ) / 1000)
`define SPE_ENABLE_CYC     ((`SPE_ENABLE_NS * `SPE_CLK_MHZ) / 1000)
`define SPE_DISABLE_COUNT  63
`define SPE_ENABLE_COUNT   32
`define SPE_QUAL_NS        1000
`define SPE_QUAL_CYC       ((`SPE_QUAL_NS * `SPE_CLK_MHZ) / 1000)
`define SPE_WAKE_PERIOD_NS 30000
`define SPE_WAKE_PERIOD_CYC ((`SPE_WAKE_PERIOD_NS * `SPE_CLK_MHZ) / 1000)
`define SPE_WAKE_WIDTH_CYC 8
`define SPE_TIMER_W        24
`endif

// file: logic/spe_wake_gen.sv
// wake pulse generator: repeats short pulses while armed
// assumes arm is cleared by the caller on a power cycle or undervoltage
`timescale 1ns/10ps
`include "spe_map.svh"
module spe_wake_gen
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  input  wire logic stop,
  output logic      wake_pulse
);
  import spe_pkg::*;

  logic        armed;
  logic        next_armed;
  logic [15:0] tick;
  logic [15:0] next_tick;

  // arm on droop, disarm on stop; stop beats a new trigger
  always_comb
  begin
    next_armed = armed;
    next_tick  = tick;
    if (stop)
    begin
      next_armed = 1'b0;
      next_tick  = 16'h0000;
    end
    else if (trigger && !armed)
    begin
      next_armed = 1'b1;
      next_tick  = 16'h0000;
    end
    else if (armed)
    begin
      if (tick == 16'(`SPE_WAKE_PERIOD_CYC - 1))
        next_tick = 16'h0000;
      else
        next_tick = tick + 16'h0001;
    end
  end

  // registers only; the decisions sit in the block above
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      armed <= 1'b0;
      tick  <= 16'h0000;
    end
    else
    begin
      armed <= next_armed;
      tick  <= next_tick;
    end
  end

  // first pulse leaves right after arming
  assign wake_pulse = armed && (tick < 16'(`SPE_WAKE_WIDTH_CYC));

  AST_WAKE_REPEAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    armed && !stop && tick == 16'(`SPE_WAKE_PERIOD_CYC - 1)
    |=> wake_pulse)
    else $error("wake pulse did not repeat");
  AST_WAKE_STOP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    stop |=> !wake_pulse)
    else $error("wake pulse after stop");
endmodule // spe_wake_gen

// file: logic/spe_counter.sv
// switch period enable counter: period timer, hysteresis counts,
// open-drain enable output and wake request
// assumes sense_low and droop_detect are synchronous to sys_clk
//
// Functional notes
// - after reset output released while periods under disable interval
// - pull output low after 63 consecutive periods above disable interval
// - any period under disable interval clears the consecutive count
// - once pulled, stay pulled until periods drop below enable interval
// - release output after 32 cumulative periods below enable interval
// - long periods between short ones never reduce the enable count
// - wake events leave output state and both counts alone
// - in either state, supply droop raises a wake request
// - enable output is pull-down only, never driven high
// - detect only when sense stayed low past the qualifying time
// - wake pulses repeat until a power cycle or undervoltage
`timescale 1ns/10ps
`include "spe_map.svh"
module spe_counter
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic sense_low,
  input  wire logic droop_detect,
  input  wire logic undervoltage,
  output logic      secondary_enable_out_o,
  output logic      secondary_enable_out_oe_n,
  output logic      wake_o,
  output logic      wake_oe_n,
  output logic      power_cycle_detect,
  output spe_pkg::spe_state_t enable_state
);
  import spe_pkg::*;

  localparam int TW = `SPE_TIMER_W;

  logic [TW-1:0] qual_cnt;
  logic [TW-1:0] next_qual_cnt;
  logic          qualified;
  logic          next_qualified;
  logic          sense_prev;
  logic          next_sense_prev;
  logic [TW-1:0] period;
  logic [TW-1:0] next_period;
  logic          seen_first;
  logic          next_seen_first;
  logic [5:0]    dis_cnt;
  logic [5:0]    next_dis_cnt;
  logic [5:0]    en_cnt;
  logic [5:0]    next_en_cnt;
  spe_state_t    state;
  spe_state_t    next_state;
  logic          next_detect;
  logic          wake_pulse;
  logic          over_dis;
  logic          under_en;

  // qualify low time of the sense line; event at end of low phase
  always_comb
  begin
    next_sense_prev = sense_low;
    next_qual_cnt   = qual_cnt;
    next_qualified  = qualified;
    next_detect     = 1'b0;
    if (sense_low)
    begin
      if (qual_cnt != TW'(`SPE_QUAL_CYC))
        next_qual_cnt = qual_cnt + TW'(1);
      else
        next_qualified = 1'b1;
    end
    else
    begin
      next_qual_cnt  = '0;
      next_qualified = 1'b0;
      next_detect    = sense_prev && qualified;
    end
  end

  // a period equal to an interval counts as neither long nor short
  assign over_dis = period > TW'(`SPE_DISABLE_CYC);
  assign under_en = period < TW'(`SPE_ENABLE_CYC);

  // period timer and the two counters, stepped on each detect
  // wake_pulse is not an input here, so wake events cannot touch this
  always_comb
  begin
    next_period     = period;
    next_seen_first = seen_first;
    next_dis_cnt    = dis_cnt;
    next_en_cnt     = en_cnt;
    next_state      = state;
    if (period != '1)
      next_period = period + TW'(1); // saturate on very long gaps
    if (next_detect)
    begin
      next_period     = TW'(1);
      next_seen_first = 1'b1;
      if (seen_first)
      begin
        unique case (state)
          SPE_RELEASED:
          begin
            next_en_cnt = 6'h00;
            if (!over_dis)
              next_dis_cnt = 6'h00;
            else if (dis_cnt == 6'(`SPE_DISABLE_COUNT - 1))
            begin
              next_dis_cnt = 6'h00;
              next_state   = SPE_PULLED;
            end
            else
              next_dis_cnt = dis_cnt + 6'h01;
          end
          SPE_PULLED:
          begin
            next_dis_cnt = 6'h00;
            if (under_en)
            begin
              if (en_cnt == 6'(`SPE_ENABLE_COUNT - 1))
              begin
                next_en_cnt = 6'h00;
                next_state  = SPE_RELEASED;
              end
              else
                next_en_cnt = en_cnt + 6'h01;
            end
            // long periods keep the count as it stands
          end
        endcase
      end
    end
  end

  // state registers only; every decision is made in the blocks above
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      qual_cnt           <= '0;
      qualified          <= 1'b0;
      sense_prev         <= 1'b0;
      period             <= '0;
      seen_first         <= 1'b0;
      dis_cnt            <= 6'h00;
      en_cnt             <= 6'h00;
      state              <= SPE_RELEASED;
      power_cycle_detect <= 1'b0;
    end
    else
    begin
      qual_cnt           <= next_qual_cnt;
      qualified          <= next_qualified;
      sense_prev         <= next_sense_prev;
      period             <= next_period;
      seen_first         <= next_seen_first;
      dis_cnt            <= next_dis_cnt;
      en_cnt             <= next_en_cnt;
      state              <= next_state;
      power_cycle_detect <= next_detect;
    end
  end

  // wake burst; a detect or undervoltage ends it
  spe_wake_gen u_wake
  (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .trigger    (droop_detect && !undervoltage),
    .stop       (next_detect || undervoltage),
    .wake_pulse (wake_pulse)
  );

  // both pins are pull-down only; enable low means the switch is on
  assign secondary_enable_out_o    = 1'b0;
  assign secondary_enable_out_oe_n = (state != SPE_PULLED);
  assign wake_o                    = 1'b0;
  assign wake_oe_n                 = !wake_pulse;
  assign enable_state              = state;

  // hysteresis, wake, open-drain and detect checks; counts only move at a qualified detect
  AST_DIS_PULL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    next_detect && seen_first && state == SPE_RELEASED && over_dis
    && dis_cnt == 6'h3e |=> state == SPE_PULLED)
    else $error("output not pulled after 63 long periods");
  AST_DIS_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    next_detect && seen_first && state == SPE_RELEASED && !over_dis
    |=> dis_cnt == 6'h00 && state == SPE_RELEASED)
    else $error("short period did not clear disable count");
  AST_STAY_REL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == SPE_RELEASED && dis_cnt < 6'h3e |=> state == SPE_RELEASED)
    else $error("output pulled too early");
  AST_EN_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    next_detect && state == SPE_PULLED && under_en && en_cnt == 6'h1f
    |=> state == SPE_RELEASED)
    else $error("output not released after 32 short periods");
  AST_EN_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == SPE_PULLED && !(next_detect && under_en)
    |=> state == SPE_PULLED && en_cnt == $past(en_cnt))
    else $error("pulled state or enable count changed without short period");
  AST_EN_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == SPE_RELEASED |=> state == SPE_PULLED || en_cnt == 6'h00)
    else $error("enable count kept while released");
  AST_WAKE_NEUTRAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wake_pulse && !next_detect |=> dis_cnt == $past(dis_cnt)
    && en_cnt == $past(en_cnt) && state == $past(state))
    else $error("wake changed counts");
  AST_OD_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    secondary_enable_out_o == 1'b0 && wake_o == 1'b0)
    else $error("open drain pin driven high");
  AST_DROOP_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    droop_detect && !undervoltage && !next_detect && !u_wake.armed
    |=> !wake_oe_n)
    else $error("droop raised no wake");
  AST_DETECT_QUAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    power_cycle_detect |-> $past(qualified))
    else $error("detect without qualified low time");

  // main scenarios the bench is meant to reach
  COV_NEUTRAL: cover property (@(posedge sys_clk) disable iff (!rst_n)
    next_detect && state == SPE_PULLED && !under_en && !over_dis);
  COV_PULL: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == SPE_RELEASED ##1 state == SPE_PULLED);
  COV_RELEASE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == SPE_PULLED ##1 state == SPE_RELEASED);
  COV_WAKE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(wake_oe_n));
endmodule // spe_counter

// file: tb/spe_pwr_model.sv
// power stage model: primary controller cycles seen on the sense line
// assumes period and pulse length are changed only just after a detect
`timescale 1ns/10ps
module spe_pwr_model
(
  input  wire logic        sys_clk,
  input  wire logic        run,
  input  wire logic [17:0] period,
  input  wire logic [8:0]  hi_len,
  output logic             sense_low
);
  logic [17:0] cnt = 18'h00000;

  // one cycle per period; holding run low clears the count, so the cycle restarts
  always @(posedge sys_clk)
  begin
    if (!run || cnt >= period - 18'h00001)
      cnt <= 18'h00000;
    else
      cnt <= cnt + 18'h00001;
  end

  // sense_low high for hi_len cycles, its fall ends demagnetization
  assign sense_low = run && cnt >= 18'h00001 && cnt <= 18'({hi_len});
endmodule // spe_pwr_model

// file: tb/tb_spe_counter.sv
// self-checking bench for the switch period enable counter
// assumes spe_pwr_model drives the sense line; long periods set run time
`timescale 1ns/10ps
module tb_spe_counter;
  import spe_pkg::*;
  localparam int LIMIT = 2500000;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        droop_detect = 1'b0;
  logic        undervoltage = 1'b0;
  logic        run = 1'b0;
  logic [17:0] period = 18'h003e8;
  logic [8:0]  hi_len = 9'h0c8;
  logic        sense_low;
  logic        sec_en_o;
  logic        sec_en_oe_n;
  logic        wake_o;
  logic        wake_oe_n;
  logic        cycle_det;
  logic        sec_en_line;
  spe_state_t  enable_state;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  always #5 sys_clk = ~sys_clk;
  // pull-up on the open-drain enable line
  assign sec_en_line = sec_en_oe_n ? 1'b1 : sec_en_o;

  spe_counter u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .sense_low(sense_low), .droop_detect(droop_detect),
    .undervoltage(undervoltage), .secondary_enable_out_o(sec_en_o),
    .secondary_enable_out_oe_n(sec_en_oe_n), .wake_o(wake_o),
    .wake_oe_n(wake_oe_n), .power_cycle_detect(cycle_det),
    .enable_state(enable_state));
  spe_pwr_model u_model (.sys_clk(sys_clk), .run(run), .period(period),
    .hi_len(hi_len), .sense_low(sense_low));

  task give_verdict;
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // hang guard: a stuck wait counts as a failure
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_errors++;
      give_verdict;
    end
  end

  // sampling on the falling edge keeps clear of input updates
  task wait_detect;
    @(negedge sys_clk);
    while (cycle_det !== 1'b1)
      @(negedge sys_clk);
  endtask

  task periods(input int n, input logic [17:0] p);
    @(posedge sys_clk) period <= p;
    repeat (n) wait_detect;
  endtask

  task count_low(input int n, output int lo);
    lo = 0;
    repeat (n)
    begin
      @(negedge sys_clk);
      if (wake_oe_n === 1'b0)
        lo++;
    end
  endtask

  task t_idle;
    @(negedge sys_clk);
    chk("state", SPE_RELEASED, enable_state);
    chk("sec_en_oe_n", 1'b1, sec_en_oe_n);
    chk("sec_en_o", 1'b0, sec_en_o);
    chk("wake_o", 1'b0, wake_o);
    chk("wake_oe_n", 1'b1, wake_oe_n);
    chk("detect", 1'b0, cycle_det);
  endtask

  task t_short_pulse;
    int k;
    k = 0;
    @(posedge sys_clk) hi_len <= 9'h032;
    run <= 1'b1;
    repeat (3000)
    begin
      @(negedge sys_clk);
      if (cycle_det === 1'b1)
        k++;
    end
    chk("short detects", 0, k);
    @(posedge sys_clk) hi_len <= 9'h0c8;
    wait_detect;
    periods(4, 18'h003e8);
    chk("state", SPE_RELEASED, enable_state);
  endtask

  task t_disable;
    periods(30, 18'h04588);
    periods(1, 18'h03e80);
    periods(62, 18'h04588);
    chk("state", SPE_RELEASED, enable_state);
    periods(1, 18'h04588);
    chk("state", SPE_PULLED, enable_state);
    chk("sec_en_line", 1'b0, sec_en_line);
  endtask

  // wake mid-way; the paused gap is a neutral period
  task wake(input spe_state_t st);
    int lo;
    @(posedge sys_clk) run <= 1'b0;
    @(posedge sys_clk) droop_detect <= 1'b1;
    @(posedge sys_clk) droop_detect <= 1'b0;
    count_low(20, lo);
    chk("wake width", 8, lo);
    count_low(3000, lo);
    chk("wake repeat", 8, lo);
    @(posedge sys_clk) undervoltage <= 1'b1;
    @(posedge sys_clk) undervoltage <= 1'b0;
    count_low(3100, lo);
    chk("wake stopped", 0, lo);
    chk("state", st, enable_state);
    repeat (9000) @(posedge sys_clk);
    period <= 18'h03e80;
    run <= 1'b1;
  endtask

  task t_hold_release;
    periods(3, 18'h03e80);
    chk("state", SPE_PULLED, enable_state);
    periods(20, 18'h003e8);
    wake(SPE_PULLED);
    periods(5, 18'h03e80);
    periods(11, 18'h003e8);
    chk("state", SPE_PULLED, enable_state);
    periods(1, 18'h003e8);
    chk("state", SPE_RELEASED, enable_state);
    chk("sec_en_line", 1'b1, sec_en_line);
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_idle;
    t_short_pulse;
    t_disable;
    t_hold_release;
    wake(SPE_RELEASED);
    give_verdict;
  end
endmodule // tb_spe_counter
